// ==== common/term_cfg_pkg.sv ====
// constants and helpers for the termination and system-enable configuration register
package term_cfg_pkg;

  localparam logic [7:0] CFG_ADDR       = 8'h11;
  localparam logic [7:0] CFG_RESET      = 8'h40;
  localparam int         CODE_MSB       = 7;
  localparam int         CODE_LSB       = 5;
  localparam int         C20_BIT        = 4;
  localparam int         C10_BIT        = 3;
  localparam int         C5_BIT         = 2;
  localparam int         SEL_MSB        = 1;
  localparam int         SEL_LSB        = 0;
  localparam int         CHG_W          = 12;
  localparam int         TERM_W         = 9;

  // currents are counted in steps of 0.5 mA
  localparam logic [11:0] DIV_C20       = 12'h014;
  localparam logic [11:0] DIV_C10       = 12'h00a;
  localparam logic [11:0] DIV_C5        = 12'h005;
  localparam logic [8:0]  TERM_MIN      = 9'h019;
  localparam logic [8:0]  TERM_MAX      = 9'h154;

  localparam logic [1:0] SEL_LDO        = 2'h0;
  localparam logic [1:0] SEL_BATT       = 2'h1;
  localparam logic [1:0] SEL_WEAK_ISO   = 2'h2;
  localparam logic [1:0] SEL_MODE       = 2'h3;

  function automatic logic [8:0] term_table(input logic [2:0] code);
    case (code)
      3'h0:    term_table = 9'h019;
      3'h1:    term_table = 9'h041;
      3'h2:    term_table = 9'h069;
      3'h3:    term_table = 9'h091;
      3'h4:    term_table = 9'h0b9;
      3'h5:    term_table = 9'h0eb;
      3'h6:    term_table = 9'h11d;
      default: term_table = 9'h154;
    endcase
  endfunction

  function automatic logic [8:0] clamp_term(input logic [11:0] val);
    if (val < {3'h0, TERM_MIN}) begin
      clamp_term = TERM_MIN;
    end else if (val > {3'h0, TERM_MAX}) begin
      clamp_term = TERM_MAX;
    end else begin
      clamp_term = val[8:0];
    end
  endfunction

endpackage

// ==== common/term_if.sv ====
// carrier between the config register and the termination current resolver
`timescale 1ns/100ps
interface term_if;
  logic [2:0]  code;
  logic [2:0]  ratio;
  logic [11:0] charge;
  logic [8:0]  current;

  modport calc (input code, input ratio, input charge, output current);
  modport user (output code, output ratio, output charge, input current);
endinterface

// ==== logic/term_resolve.sv ====
// resolves the effective termination current from the stored selection bits
`timescale 1ns/100ps
module term_resolve (
  term_if.calc t
);

  // ratio bits arrive as {c20, c10, c5}; priority is applied here only, never to storage
  always_comb begin
    if (t.ratio[2]) begin
      t.current = term_cfg_pkg::clamp_term(t.charge / term_cfg_pkg::DIV_C20);
    end else if (t.ratio[1]) begin
      t.current = term_cfg_pkg::clamp_term(t.charge / term_cfg_pkg::DIV_C10);
    end else if (t.ratio[0]) begin
      t.current = term_cfg_pkg::clamp_term(t.charge / term_cfg_pkg::DIV_C5);
    end else begin
      t.current = term_cfg_pkg::term_table(t.code);
    end
  end

endmodule

// ==== logic/term_sysgood_cfg.sv ====
// termination current and system-enable configuration register with its decode logic
//
// Behaviour
// - bits 7 to 5 pick one of eight fixed termination currents from 12.5 mA to 170.0 mA, reset code 010.
// - bit 4 set makes termination the charge current over 20, overriding every other selection.
// - bit 3 set with bit 4 clear makes termination the charge current over 10.
// - bit 2 set with bits 3 and 4 clear makes termination the charge current over 5.
// - any ratio-based termination is clamped between 12.5 mA and 170 mA.
// - select 00 raises system enable when the LDO is active and system voltage is present.
// - select 01 drives system enable from the battery node voltage in charging mode.
// - select 10 raises system enable and turns off the isolation FET when the battery is below weak.
// - the select 10 behaviour acts only with input supply at 0 V and the battery monitor on.
// - select 11 raises system enable in LDO mode, and in charging mode only at or above weak.
// - the register sits at address 0x11 of the serial-bus register map.
`timescale 1ns/100ps
module term_sysgood_cfg (
  input  wire logic        i_clk,
  input  wire logic        i_rst,
  input  wire logic        i_ce,
  input  wire logic [7:0]  i_reg_addr,
  input  wire logic        i_reg_wr,
  input  wire logic [7:0]  i_reg_wdata,
  input  wire logic        i_reg_rd,
  input  wire logic [11:0] i_charge_current,
  input  wire logic        i_ldo_active,
  input  wire logic        i_sys_voltage_ok,
  input  wire logic        i_charging_mode,
  input  wire logic        i_batt_above_weak,
  input  wire logic        i_input_supply_zero,
  input  wire logic        i_battery_monitor_on,
  output logic      [7:0]  o_reg_rdata,
  output logic      [8:0]  o_term_current,
  output logic             o_system_enable_pin,
  output logic             o_iso_fet_off
);

  logic [7:0] cfg;
  logic [1:0] sel;
  logic       next_sysen;
  logic       next_fet_off;
  logic       weak_opt_live;

  term_if t ();

  term_resolve u_resolve (
    .t (t.calc)
  );

  assign t.code   = cfg[term_cfg_pkg::CODE_MSB:term_cfg_pkg::CODE_LSB];
  assign t.ratio  = cfg[term_cfg_pkg::C20_BIT:term_cfg_pkg::C5_BIT];
  assign t.charge = i_charge_current;
  assign sel      = cfg[term_cfg_pkg::SEL_MSB:term_cfg_pkg::SEL_LSB];

  // register storage: bits are kept exactly as written
  always_ff @(posedge i_clk or posedge i_rst) begin
    if (i_rst) begin
      cfg <= term_cfg_pkg::CFG_RESET;
    end else if (i_ce && i_reg_wr && i_reg_addr == term_cfg_pkg::CFG_ADDR) begin
      cfg <= i_reg_wdata;
    end
  end

  // read data is registered; other addresses belong to other blocks and read as zero here
  always_ff @(posedge i_clk or posedge i_rst) begin
    if (i_rst) begin
      o_reg_rdata <= 8'h00;
    end else if (i_ce && i_reg_rd) begin
      if (i_reg_addr == term_cfg_pkg::CFG_ADDR) begin
        o_reg_rdata <= cfg;
      end else begin
        o_reg_rdata <= 8'h00;
      end
    end
  end

  // the divide path is combinational; registering it here keeps the output free of glitches
  always_ff @(posedge i_clk or posedge i_rst) begin
    if (i_rst) begin
      o_term_current <= term_cfg_pkg::term_table(term_cfg_pkg::CFG_RESET[7:5]);
    end else if (i_ce) begin
      o_term_current <= t.current;
    end
  end

  assign weak_opt_live = i_input_supply_zero && i_battery_monitor_on;

  always_comb begin
    next_sysen   = 1'b0;
    next_fet_off = 1'b0;
    case (sel)
      term_cfg_pkg::SEL_LDO: begin
        next_sysen = i_ldo_active && i_sys_voltage_ok;
      end
      term_cfg_pkg::SEL_BATT: begin
        next_sysen = i_charging_mode && i_batt_above_weak;
      end
      term_cfg_pkg::SEL_WEAK_ISO: begin
        // inactive outside its qualifying condition: the FET stays on and the pin stays low
        if (weak_opt_live && !i_batt_above_weak) begin
          next_sysen   = 1'b1;
          next_fet_off = 1'b1;
        end
      end
      default: begin
        // charging mode decides which condition gates the pin
        if (i_charging_mode) begin
          next_sysen = i_batt_above_weak;
        end else begin
          next_sysen = i_ldo_active;
        end
      end
    endcase
  end

  always_ff @(posedge i_clk or posedge i_rst) begin
    if (i_rst) begin
      o_system_enable_pin <= 1'b0;
      o_iso_fet_off       <= 1'b0;
    end else if (i_ce) begin
      o_system_enable_pin <= next_sysen;
      o_iso_fet_off       <= next_fet_off;
    end
  end

  table_code_a: assert property (@(posedge i_clk) disable iff (i_rst)
    (i_ce && cfg[4:2] == 3'h0) |=> o_term_current == term_cfg_pkg::term_table($past(cfg[7:5])))
    else $error("fixed termination code not applied");

  ratio_c20_a: assert property (@(posedge i_clk) disable iff (i_rst)
    (i_ce && cfg[4]) |=> o_term_current == term_cfg_pkg::clamp_term($past(i_charge_current) / 12'h014))
    else $error("divide by 20 not applied");

  ratio_c10_a: assert property (@(posedge i_clk) disable iff (i_rst)
    (i_ce && cfg[4:3] == 2'h1) |=> o_term_current == term_cfg_pkg::clamp_term($past(i_charge_current) / 12'h00a))
    else $error("divide by 10 not applied");

  ratio_c5_a: assert property (@(posedge i_clk) disable iff (i_rst)
    (i_ce && cfg[4:2] == 3'h1) |=> o_term_current == term_cfg_pkg::clamp_term($past(i_charge_current) / 12'h005))
    else $error("divide by 5 not applied");

  ratio_clamp_a: assert property (@(posedge i_clk) disable iff (i_rst)
    (i_ce && cfg[4:2] != 3'h0) |=> (o_term_current >= 9'h019 && o_term_current <= 9'h154))
    else $error("ratio termination out of range");

  sel_ldo_a: assert property (@(posedge i_clk) disable iff (i_rst)
    (i_ce && sel == 2'h0) |=> o_system_enable_pin == ($past(i_ldo_active) && $past(i_sys_voltage_ok)))
    else $error("select 00 system enable wrong");

  sel_batt_a: assert property (@(posedge i_clk) disable iff (i_rst)
    (i_ce && sel == 2'h1) |=> o_system_enable_pin == ($past(i_charging_mode) && $past(i_batt_above_weak)))
    else $error("select 01 system enable wrong");

  weak_iso_a: assert property (@(posedge i_clk) disable iff (i_rst)
    (i_ce && sel == 2'h2 && i_input_supply_zero && i_battery_monitor_on && !i_batt_above_weak)
      |=> (o_system_enable_pin && o_iso_fet_off))
    else $error("weak battery isolation not applied");

  weak_gate_a: assert property (@(posedge i_clk) disable iff (i_rst)
    (i_ce && !(i_input_supply_zero && i_battery_monitor_on)) |=> !o_iso_fet_off)
    else $error("isolation FET turned off without qualifying condition");

  sel_mode_a: assert property (@(posedge i_clk) disable iff (i_rst)
    (i_ce && sel == 2'h3 && i_charging_mode) |=> o_system_enable_pin == $past(i_batt_above_weak))
    else $error("select 11 charging-mode enable wrong");

  write_read_a: assert property (@(posedge i_clk) disable iff (i_rst)
    (i_ce && i_reg_wr && i_reg_addr == 8'h11 ##1 i_ce && i_reg_rd && !i_reg_wr && i_reg_addr == 8'h11)
      |=> o_reg_rdata == $past(i_reg_wdata, 2))
    else $error("register read back differs from write");

  // a low enable must freeze everything, so a gated host clock never corrupts the setting
  cfg_hold_a: assert property (@(posedge i_clk) disable iff (i_rst)
    !i_ce |=> $stable(cfg))
    else $error("register changed while clock enable low");

  ce_hold_a: assert property (@(posedge i_clk) disable iff (i_rst)
    !i_ce |=> ($stable(o_term_current) && $stable(o_system_enable_pin) && $stable(o_iso_fet_off)
      && $stable(o_reg_rdata)))
    else $error("outputs moved while clock enable low");

  cfg_write_a: assert property (@(posedge i_clk) disable iff (i_rst)
    (i_ce && i_reg_wr && i_reg_addr == term_cfg_pkg::CFG_ADDR) |=> cfg == $past(i_reg_wdata))
    else $error("write to the config address not stored");

  other_addr_a: assert property (@(posedge i_clk) disable iff (i_rst)
    (i_reg_addr != term_cfg_pkg::CFG_ADDR) |=> $stable(cfg))
    else $error("access to another address changed the register");

  unmapped_read_a: assert property (@(posedge i_clk) disable iff (i_rst)
    (i_ce && i_reg_rd && i_reg_addr != term_cfg_pkg::CFG_ADDR) |=> o_reg_rdata == 8'h00)
    else $error("read of another address not zero");

  read_value_a: assert property (@(posedge i_clk) disable iff (i_rst)
    (i_ce && i_reg_rd && i_reg_addr == term_cfg_pkg::CFG_ADDR) |=> o_reg_rdata == $past(cfg))
    else $error("read data is not the stored value");

  read_hold_a: assert property (@(posedge i_clk) disable iff (i_rst)
    !(i_ce && i_reg_rd) |=> $stable(o_reg_rdata))
    else $error("read data moved without a read");

  sel_ldo_mode_a: assert property (@(posedge i_clk) disable iff (i_rst)
    (i_ce && sel == term_cfg_pkg::SEL_MODE && !i_charging_mode)
      |=> o_system_enable_pin == $past(i_ldo_active))
    else $error("select 11 ldo-mode enable wrong");

  fet_sel_only_a: assert property (@(posedge i_clk) disable iff (i_rst)
    (i_ce && sel != term_cfg_pkg::SEL_WEAK_ISO) |=> !o_iso_fet_off)
    else $error("isolation FET turned off outside select 10");

  weak_idle_a: assert property (@(posedge i_clk) disable iff (i_rst)
    (i_ce && sel == term_cfg_pkg::SEL_WEAK_ISO && !(i_input_supply_zero && i_battery_monitor_on && !i_batt_above_weak))
      |=> (!o_system_enable_pin && !o_iso_fet_off))
    else $error("select 10 active outside its condition");

  fet_pair_a: assert property (@(posedge i_clk) disable iff (i_rst)
    o_iso_fet_off |-> o_system_enable_pin)
    else $error("isolation FET off without system enable");

  term_range_a: assert property (@(posedge i_clk) disable iff (i_rst)
    o_term_current >= term_cfg_pkg::TERM_MIN && o_term_current <= term_cfg_pkg::TERM_MAX)
    else $error("termination current outside its range");

endmodule

// ==== verification/tb_term_sysgood_cfg.sv ====
// self-checking bench for the termination and system-enable config register
`timescale 1ns/100ps
module tb_term_sysgood_cfg;
  logic        clk;
  logic        rst;
  logic        ce;
  logic        wr;
  logic        rd;
  logic        ldo;
  logic        sok;
  logic        chm;
  logic        abw;
  logic        inz;
  logic        bmon;
  logic        sen;
  logic        iso;
  logic [7:0]  addr;
  logic [7:0]  wdata;
  logic [7:0]  rdata;
  logic [11:0] chg;
  logic [8:0]  term;
  int          num_errors = 0;
  int          n_compared = 0;
  logic [8:0]  tab [8] = '{9'h019, 9'h041, 9'h069, 9'h091, 9'h0b9, 9'h0eb, 9'h11d, 9'h154};
  logic [7:0]  rv [5] = '{8'hfc, 8'h0c, 8'h04, 8'h10, 8'h04};
  logic [11:0] cv [5] = '{12'h7d0, 12'h7d0, 12'h3e8, 12'h064, 12'hfa0};

  always #2 clk = ~clk;

  term_sysgood_cfg u_term_sysgood_cfg (.i_clk(clk), .i_rst(rst), .i_ce(ce), .i_reg_addr(addr),
    .i_reg_wr(wr), .i_reg_wdata(wdata), .i_reg_rd(rd), .i_charge_current(chg), .i_ldo_active(ldo),
    .i_sys_voltage_ok(sok), .i_charging_mode(chm), .i_batt_above_weak(abw),
    .i_input_supply_zero(inz), .i_battery_monitor_on(bmon), .o_reg_rdata(rdata),
    .o_term_current(term), .o_system_enable_pin(sen), .o_iso_fet_off(iso));

  task automatic check(input logic [11:0] seen, input logic [11:0] exp);
    n_compared++;
    if (seen !== exp) begin
      num_errors++;
      $display("[FAIL] t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask

  // one-cycle strobe; two negedges pass so decoded outputs have settled on return
  task automatic access(input logic w, input logic [7:0] a, input logic [7:0] d);
    addr = a;
    wdata = d;
    wr = w;
    rd = !w;
    @(negedge clk);
    wr = 1'b0;
    rd = 1'b0;
    @(negedge clk);
  endtask

  // priority is taken from the bits, not the stored value, so 0xfc still means over 20
  function automatic logic [8:0] exp_term(input logic [7:0] r, input logic [11:0] c);
    logic [11:0] v;
    if (r[4:2] == 3'h0) return tab[r[7:5]];
    v = r[4] ? c / 12'h014 : (r[3] ? c / 12'h00a : c / 12'h005);
    if (v < 12'h019) return 9'h019;
    if (v > 12'h154) return 9'h154;
    return v[8:0];
  endfunction

  // v holds {ldo, sok, chm, abw, inz, bmon}; result is {enable, fet off}
  function automatic logic [1:0] exp_sys(input logic [1:0] s, input logic [5:0] v);
    case (s)
      2'h0: return {v[5] & v[4], 1'b0};
      2'h1: return {v[3] & v[2], 1'b0};
      2'h2: return {2{v[1] & v[0] & !v[2]}};
      default: return {v[3] ? v[2] : v[5], 1'b0};
    endcase
  endfunction

  task automatic test_done;
    $display("compared %0d, mismatches %0d", n_compared, num_errors);
    if (num_errors == 0 && n_compared > 0) begin
      $display("Regression OK");
    end else begin
      $display("Regression broken");
    end
    $finish;
  endtask

  initial begin
    #20000;
    num_errors++;
    test_done();
  end

  initial begin
    clk = 1'b0;
    rst = 1'b1;
    ce = 1'b1;
    {wr, rd, addr, wdata, chg, ldo, sok, chm, abw, inz, bmon} = '0;
    repeat (5) @(negedge clk);
    check(12'(rdata), 12'h000);
    check(12'({sen, iso}), 12'h000);
    check(12'(term), 12'h069);
    rst = 1'b0;
    access(1'b0, 8'h11, 8'h00);
    check(12'(rdata), 12'h040);
    for (int c = 0; c < 8; c++) begin
      access(1'b1, 8'h11, {c[2:0], 5'h00});
      check(12'(term), 12'(tab[c]));
      access(1'b0, 8'h11, 8'h00);
      check(12'(rdata), 12'({c[2:0], 5'h00}));
    end
    for (int k = 0; k < 5; k++) begin
      chg = cv[k];
      access(1'b1, 8'h11, rv[k]);
      check(12'(term), 12'(exp_term(rv[k], cv[k])));
      access(1'b0, 8'h11, 8'h00);
      check(12'(rdata), 12'(rv[k]));
    end
    access(1'b1, 8'h12, 8'h00);
    access(1'b0, 8'h12, 8'h00);
    check(12'(rdata), 12'h000);
    check(12'(term), 12'h154);
    ce = 1'b0;
    access(1'b1, 8'h11, 8'h00);
    ce = 1'b1;
    access(1'b0, 8'h11, 8'h00);
    check(12'(rdata), 12'h004);
    // back-to-back write then read, then a write and a read in one cycle
    addr = 8'h11;
    wdata = 8'h5a;
    wr = 1'b1;
    @(negedge clk);
    wr = 1'b0;
    rd = 1'b1;
    @(negedge clk);
    check(12'(rdata), 12'h05a);
    wdata = 8'ha5;
    wr = 1'b1;
    @(negedge clk);
    check(12'(rdata), 12'h05a);
    wr = 1'b0;
    @(negedge clk);
    rd = 1'b0;
    check(12'(rdata), 12'h0a5);
    @(negedge clk);
    for (int s = 0; s < 4; s++) begin
      access(1'b1, 8'h11, {6'h00, s[1:0]});
      for (int i = 0; i < 64; i++) begin
        {ldo, sok, chm, abw, inz, bmon} = i[5:0];
        @(negedge clk);
        check(12'({sen, iso}), 12'(exp_sys(s[1:0], i[5:0])));
      end
    end
    test_done();
  end
endmodule
